// *** pkg/pors_pkg.sv ***
/*
 * Shared constants and types of the power-off and reset sequencer.
 * Assumes a single 10 MHz system clock; pulse thresholds are counted in cycles.
 */
package pors_pkg;
    // =========================================================
    // pin timing defaults, in clk_sys cycles
    localparam int unsigned CNT_W             = 24;
    localparam logic [23:0] PULSE_MIN_CYC_DEF = 24'h0003E8;  // shortest valid low pulse
    localparam logic [23:0] LONG_HOLD_CYC_DEF = 24'h0186A0;  // hold that forces a hard reboot
    localparam logic [23:0] RESET_MIN_CYC_DEF = 24'h0003E8;  // reset pin low time that shuts down

    // =========================================================
    // function-level command values
    localparam logic [7:0]  FUNC_FAST_OFF     = 8'h0A;
    localparam logic [7:0]  FUNC_REBOOT_DEF   = 8'h0F;

    // =========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_UNPOWERED,
        ST_OFF,
        ST_ON,
        ST_GASP,
        ST_SAVE,
        ST_DETACH,
        ST_DOWN
    } pors_state_t;
endpackage

// *** pkg/pors_pin_if.sv ***
/*
 * Events from a pin filter to the sequencer.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/1ps
interface pors_pin_if;
    logic pulse_ok;   // valid low pulse just released
    logic long_hold;  // pin held low for the long threshold
    modport filt (output pulse_ok, output long_hold);
    modport seq  (input  pulse_ok, input  long_hold);
endinterface

// *** verilog/pors_pin_filter.sv ***
/*
 * Low-pulse qualifier for an active-low control pin with internal pull-up.
 * Assumes the pin is asynchronous to clk_sys; it is synchronised here.
 */
`timescale 1ns/1ps
module pors_pin_filter #(
    parameter logic [23:0] PULSE_MIN = pors_pkg::PULSE_MIN_CYC_DEF,
    parameter logic [23:0] LONG_HOLD = pors_pkg::LONG_HOLD_CYC_DEF
) (
    input  wire logic   clk_sys,
    input  wire logic   srst,
    input  wire logic   pin_n,
    pors_pin_if.filt    ev
);
    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        prev;
        logic [23:0] cnt;
        logic        pulse_ok;
        logic        long_hold;
    } pors_filt_t;

    pors_filt_t r_reg;
    pors_filt_t r_next;

    // =========================================================
    // next state: count low time, flag a long hold while still low, judge a pulse at release
    always_comb
    begin
        r_next           = r_reg;
        r_next.sync1     = pin_n;
        r_next.sync2     = r_reg.sync1;
        r_next.prev      = r_reg.sync2;
        r_next.pulse_ok  = 1'b0;
        r_next.long_hold = 1'b0;
        if (!r_reg.sync2)
        begin
            // saturate so a stuck-low pin cannot wrap into a short pulse
            if (r_reg.cnt < LONG_HOLD)
                r_next.cnt = r_reg.cnt + 24'h000001;
            if (r_reg.cnt == LONG_HOLD - 24'h000001)
                r_next.long_hold = 1'b1;
        end
        else
        begin
            r_next.cnt = 24'h000000;
            // release: a long hold already acted, so it is not also a pulse
            if (!r_reg.prev && r_reg.cnt >= PULSE_MIN && r_reg.cnt < LONG_HOLD)
                r_next.pulse_ok = 1'b1;
        end
    end

    // =========================================================
    // state register; pins idle high as the pull-up holds them
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            r_reg       <= '0;
            r_reg.sync1 <= 1'b1;
            r_reg.sync2 <= 1'b1;
            r_reg.prev  <= 1'b1;
        end
        else
            r_reg <= r_next;
    end

    assign ev.pulse_ok  = r_reg.pulse_ok;
    assign ev.long_hold = r_reg.long_hold;

    // =========================================================
    // checks
    AST_PULSE_LEN: assert property (@(posedge clk_sys) disable iff (srst)
        r_reg.pulse_ok |-> ($past(r_reg.cnt) >= PULSE_MIN && $past(r_reg.cnt) < LONG_HOLD))
        else $error("pulse accepted with wrong low time");
endmodule

// *** verilog/pors_sequencer.sv ***
/*
 * Power-off and reset sequencer of a cellular modem: graceful and fast
 * switch-off, last-gasp off, soft reboot, abrupt pin shutdown and reboot.
 * Assumes firmware handshakes (save, detach, last gasp) run on clk_sys and
 * that the control and supply pins are asynchronous.
 */
`timescale 1ns/1ps
module pors_sequencer #(
    parameter logic [23:0] PULSE_MIN_CYC   = pors_pkg::PULSE_MIN_CYC_DEF,
    parameter logic [23:0] LONG_HOLD_CYC   = pors_pkg::LONG_HOLD_CYC_DEF,
    parameter logic [23:0] RESET_MIN_CYC   = pors_pkg::RESET_MIN_CYC_DEF,
    parameter logic [7:0]  FUNC_REBOOT     = pors_pkg::FUNC_REBOOT_DEF,
    parameter logic        HAS_FAST_OFF    = 1'b1,
    parameter logic        HAS_RESET_PIN   = 1'b1,
    parameter logic        HAS_HARD_REBOOT = 1'b1
) (
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       power_control_input_n,
    input  wire logic       reset_input_n,
    input  wire logic       supply_present,
    input  wire logic       fast_off_gpio,
    input  wire logic       switch_off_command,
    input  wire logic       func_cmd_valid,
    input  wire logic [7:0] func_cmd_value,
    input  wire logic       last_gasp_enable,
    input  wire logic       last_gasp_trigger,
    input  wire logic       last_gasp_sent,
    input  wire logic       save_done,
    input  wire logic       detach_done,
    output logic            switch_off_ok,
    output logic            save_req,
    output logic            detach_req,
    output logic            last_gasp_command,
    output logic            interface_supply_on,
    output logic            pins_tristate,
    output logic            regulators_on
);
    typedef struct packed {
        pors_pkg::pors_state_t st;
        logic sup1;
        logic sup2;
        logic gp1;
        logic gp2;
        logic gp3;
        logic reboot;
        logic skip;
        logic ok;
        logic save;
        logic detach;
        logic gasp;
        logic vint;
        logic tri_pins;
        logic regs;
    } pors_seq_t;

    pors_seq_t r_reg;
    pors_seq_t r_next;

    pors_pin_if pc_ev ();
    pors_pin_if rst_ev ();

    // =========================================================
    // pin qualifiers
    pors_pin_filter #(
        .PULSE_MIN (PULSE_MIN_CYC),
        .LONG_HOLD (LONG_HOLD_CYC)
    ) u_pc_filt (
        .clk_sys (clk_sys),
        .srst    (srst),
        .pin_n   (power_control_input_n),
        .ev      (pc_ev)
    );

    pors_pin_filter #(
        .PULSE_MIN (RESET_MIN_CYC),
        .LONG_HOLD (RESET_MIN_CYC)
    ) u_rst_filt (
        .clk_sys (clk_sys),
        .srst    (srst),
        .pin_n   (reset_input_n),
        .ev      (rst_ev)
    );

    // running states, where an abrupt pin event may cut in
    function automatic logic is_live(input pors_pkg::pors_state_t s);
        is_live = (s == pors_pkg::ST_ON) || (s == pors_pkg::ST_GASP)
               || (s == pors_pkg::ST_SAVE) || (s == pors_pkg::ST_DETACH);
    endfunction

    logic abrupt_off;
    logic hard_boot;
    logic gpio_toggle;
    logic fast_req;
    logic boot_req;

    // =========================================================
    // event decode
    assign abrupt_off  = HAS_RESET_PIN & rst_ev.long_hold;
    assign hard_boot   = HAS_HARD_REBOOT & pc_ev.long_hold;
    assign gpio_toggle = r_reg.gp2 ^ r_reg.gp3;
    assign fast_req    = HAS_FAST_OFF & ((func_cmd_valid & (func_cmd_value == pors_pkg::FUNC_FAST_OFF))
                       | gpio_toggle);
    assign boot_req    = func_cmd_valid & (func_cmd_value == FUNC_REBOOT);

    // =========================================================
    // sequencer next state
    always_comb
    begin
        r_next      = r_reg;
        r_next.ok   = 1'b0;
        r_next.sup1 = supply_present;
        r_next.sup2 = r_reg.sup1;
        r_next.gp1  = fast_off_gpio;
        r_next.gp2  = r_reg.gp1;
        r_next.gp3  = r_reg.gp2;
        case (r_reg.st)
            pors_pkg::ST_UNPOWERED:
                if (r_reg.sup2)
                    r_next.st = pors_pkg::ST_OFF;
            pors_pkg::ST_OFF:
                if (pc_ev.pulse_ok)
                    r_next.st = pors_pkg::ST_ON;
            pors_pkg::ST_ON:
                if (switch_off_command)
                begin
                    r_next.st     = pors_pkg::ST_SAVE;
                    r_next.ok     = 1'b1;
                    r_next.skip   = 1'b0;
                    r_next.reboot = 1'b0;
                end
                else if (pc_ev.pulse_ok)
                begin
                    r_next.st     = pors_pkg::ST_SAVE;
                    r_next.skip   = 1'b0;
                    r_next.reboot = 1'b0;
                end
                else if (fast_req)
                begin
                    r_next.st     = pors_pkg::ST_SAVE;
                    r_next.skip   = 1'b1;
                    r_next.reboot = 1'b0;
                end
                else if (boot_req)
                begin
                    r_next.st     = pors_pkg::ST_SAVE;
                    r_next.skip   = 1'b0;
                    r_next.reboot = 1'b1;
                end
                else if (last_gasp_enable && last_gasp_trigger)
                begin
                    r_next.st     = pors_pkg::ST_GASP;
                    r_next.skip   = 1'b0;
                    r_next.reboot = 1'b0;
                end
            pors_pkg::ST_GASP:
                if (last_gasp_sent)
                    r_next.st = pors_pkg::ST_SAVE;
            pors_pkg::ST_SAVE:
                if (save_done)
                    r_next.st = r_reg.skip ? pors_pkg::ST_DOWN : pors_pkg::ST_DETACH;
            pors_pkg::ST_DETACH:
                if (detach_done)
                    r_next.st = pors_pkg::ST_DOWN;
            pors_pkg::ST_DOWN:
                r_next.st = r_reg.reboot ? pors_pkg::ST_ON : pors_pkg::ST_OFF;
            default:
                r_next.st = pors_pkg::ST_UNPOWERED;
        endcase
        // abrupt pin events override any routine in progress
        if (is_live(r_reg.st) && abrupt_off)
        begin
            r_next.st     = pors_pkg::ST_DOWN;
            r_next.reboot = 1'b0;
            r_next.ok     = 1'b0;
        end
        else if (is_live(r_reg.st) && hard_boot)
        begin
            r_next.st     = pors_pkg::ST_DOWN;
            r_next.reboot = 1'b1;
            r_next.ok     = 1'b0;
        end
        // supply loss beats everything; nothing can be saved
        if (!r_reg.sup2)
        begin
            r_next.st     = pors_pkg::ST_UNPOWERED;
            r_next.reboot = 1'b0;
            r_next.ok     = 1'b0;
        end
        // outputs follow the next state so they leave a flip-flop
        r_next.save     = (r_next.st == pors_pkg::ST_SAVE);
        r_next.detach   = (r_next.st == pors_pkg::ST_DETACH);
        r_next.gasp     = (r_next.st == pors_pkg::ST_GASP);
        r_next.vint     = is_live(r_next.st);
        r_next.regs     = is_live(r_next.st);
        r_next.tri_pins = !is_live(r_next.st);
    end

    // =========================================================
    // state register; supply assumed absent until seen
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            r_reg          <= '0;
            r_reg.st       <= pors_pkg::ST_UNPOWERED;
            r_reg.tri_pins <= 1'b1;
        end
        else
            r_reg <= r_next;
    end

    assign switch_off_ok       = r_reg.ok;
    assign save_req            = r_reg.save;
    assign detach_req          = r_reg.detach;
    assign last_gasp_command   = r_reg.gasp;
    assign interface_supply_on = r_reg.vint;
    assign pins_tristate       = r_reg.tri_pins;
    assign regulators_on       = r_reg.regs;

    // =========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    logic pin_quiet;
    assign pin_quiet = r_reg.sup2 && !abrupt_off && !hard_boot;

    AST_SOFF_OK: assert property (
        r_reg.st == pors_pkg::ST_ON && switch_off_command && pin_quiet
        |=> switch_off_ok && save_req && !detach_req && interface_supply_on)
        else $error("switch-off not acknowledged during routine");

    AST_GRACE_DETACH: assert property (
        r_reg.st == pors_pkg::ST_SAVE && !r_reg.skip && save_done && pin_quiet
        |=> detach_req && !save_req)
        else $error("graceful off skipped detach");

    AST_FAST_SKIP: assert property (
        r_reg.st == pors_pkg::ST_SAVE && r_reg.skip && save_done && pin_quiet
        |=> !detach_req && !interface_supply_on)
        else $error("fast off performed detach");

    AST_UNPOWER: assert property (
        !r_reg.sup2 |=> r_reg.st == pors_pkg::ST_UNPOWERED && !save_req && !detach_req && !regulators_on)
        else $error("supply loss did not shut down");

    AST_RESET_ABRUPT: assert property (
        is_live(r_reg.st) && abrupt_off && r_reg.sup2
        |=> !save_req && !detach_req && !interface_supply_on ##1 (r_reg.st == pors_pkg::ST_OFF || !r_reg.sup2))
        else $error("reset pin did not shut down abruptly");

    AST_GASP_THEN_SAVE: assert property (
        r_reg.st == pors_pkg::ST_GASP && last_gasp_sent && pin_quiet
        |-> last_gasp_command ##1 (save_req && !last_gasp_command))
        else $error("last gasp not followed by save");

    AST_DOWN_OFF: assert property (
        r_reg.st == pors_pkg::ST_DOWN && !r_reg.reboot && r_reg.sup2
        |=> !interface_supply_on && pins_tristate && !regulators_on)
        else $error("routine end left supplies on");

    AST_OFF_HOLDS: assert property (
        r_reg.st == pors_pkg::ST_OFF && !pc_ev.pulse_ok && r_reg.sup2 |=> r_reg.st == pors_pkg::ST_OFF)
        else $error("left off state without switch-on");

    AST_SOFT_REBOOT: assert property (
        r_reg.st == pors_pkg::ST_DOWN && r_reg.reboot && r_reg.sup2 |=> interface_supply_on)
        else $error("reboot did not restart");

    AST_HARD_REBOOT: assert property (
        r_reg.st == pors_pkg::ST_ON && hard_boot && !abrupt_off && r_reg.sup2
        |=> !save_req && !interface_supply_on ##1 (interface_supply_on || !r_reg.sup2))
        else $error("long hold did not reboot abruptly");

    AST_SWITCH_ON: assert property (
        r_reg.st == pors_pkg::ST_OFF && pc_ev.pulse_ok && r_reg.sup2 |=> interface_supply_on && !pins_tristate)
        else $error("valid pulse did not switch on");

    COV_GRACE: cover property (switch_off_ok ##[1:1000] detach_req ##[1:1000] pins_tristate);
    COV_FAST:  cover property (r_reg.st == pors_pkg::ST_SAVE && r_reg.skip ##1 r_reg.st == pors_pkg::ST_DOWN);
    COV_GASP:  cover property (last_gasp_command ##[1:1000] detach_req);
    COV_BOOT:  cover property (r_reg.st == pors_pkg::ST_DOWN && r_reg.reboot ##1 interface_supply_on);
endmodule

// *** dv/pors_fw_model.sv ***
/*
 * Firmware stand-in: answers the save, detach and last-gasp requests of the
 * sequencer with one-cycle done pulses, promptly or slowly.
 * Assumes it shares clk_sys and srst with the sequencer.
 */
`timescale 1ns/1ps
module pors_fw_model (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic slow,
    input  wire logic save_req,
    input  wire logic detach_req,
    input  wire logic last_gasp_command,
    output logic      save_done,
    output logic      detach_done,
    output logic      last_gasp_sent
);
    // =========================================================
    // request to done delay
    logic [3:0] cnt_reg;
    logic [3:0] lim;
    logic       busy;
    assign lim  = slow ? 4'hC : 4'h1;
    assign busy = (save_req | detach_req | last_gasp_command) & ~(save_done | detach_done | last_gasp_sent);

    // one routine at a time; the count stays at zero while a done is out, so a request is never answered twice
    always_ff @(posedge clk_sys)
    begin
        save_done      <= 1'b0;
        detach_done    <= 1'b0;
        last_gasp_sent <= 1'b0;
        if (srst || !busy)
            cnt_reg <= 4'h0;
        else if (cnt_reg == lim)
        begin
            cnt_reg        <= 4'h0;
            save_done      <= save_req;
            detach_done    <= detach_req;
            last_gasp_sent <= last_gasp_command;
        end
        else
            cnt_reg <= cnt_reg + 4'h1;
    end
endmodule

// *** dv/test_power_off_reset_sequencer.sv ***
/*
 * Self-checking bench of the power-off and reset sequencer.
 * Assumes the package, the pin interface and the firmware model are compiled first.
 */
`timescale 1ns/1ps
module test_power_off_reset_sequencer;
    // =========================================================
    // stimulus and observation
    logic       clk_sys = 1'b0;
    logic       srst = 1'b1;
    logic       pc_n = 1'b1;
    logic       rs_n = 1'b1;
    logic       supply = 1'b1;
    logic       gpio = 1'b0;
    logic       off_cmd = 1'b0;
    logic       fvalid = 1'b0;
    logic [7:0] fvalue = 8'h00;
    logic       lg_en = 1'b0;
    logic       lg_trig = 1'b0;
    logic       slow = 1'b0;
    logic       lg_sent, save_done, detach_done, switch_off_ok, save_req, detach_req;
    logic       last_gasp_command, interface_supply_on, pins_tristate, regulators_on;
    logic       saw_save, saw_det, saw_gasp, saw_low, saw_ok;
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         cycles = 0;

    always #50 clk_sys = ~clk_sys;

    // small thresholds keep the run short
    pors_sequencer #(.PULSE_MIN_CYC(24'h000004), .LONG_HOLD_CYC(24'h000014),
        .RESET_MIN_CYC(24'h000004)) pors_sequencer_i (
        .clk_sys(clk_sys), .srst(srst), .power_control_input_n(pc_n), .reset_input_n(rs_n),
        .supply_present(supply), .fast_off_gpio(gpio), .switch_off_command(off_cmd),
        .func_cmd_valid(fvalid), .func_cmd_value(fvalue), .last_gasp_enable(lg_en),
        .last_gasp_trigger(lg_trig), .last_gasp_sent(lg_sent), .save_done(save_done),
        .detach_done(detach_done), .switch_off_ok(switch_off_ok), .save_req(save_req),
        .detach_req(detach_req), .last_gasp_command(last_gasp_command),
        .interface_supply_on(interface_supply_on), .pins_tristate(pins_tristate),
        .regulators_on(regulators_on));

    pors_fw_model pors_fw_model_i (
        .clk_sys(clk_sys), .srst(srst), .slow(slow), .save_req(save_req), .detach_req(detach_req),
        .last_gasp_command(last_gasp_command), .save_done(save_done), .detach_done(detach_done),
        .last_gasp_sent(lg_sent));

    // =========================================================
    // activity monitor and hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (save_req === 1'b1) saw_save <= 1'b1;
        if (detach_req === 1'b1) saw_det <= 1'b1;
        if (last_gasp_command === 1'b1) saw_gasp <= 1'b1;
        if (switch_off_ok === 1'b1) saw_ok <= 1'b1;
        if (interface_supply_on === 1'b0) saw_low <= 1'b1;
        if (cycles == 6000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // =========================================================
    // shared tasks
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic clr;
        {saw_save, saw_det, saw_gasp, saw_low, saw_ok} = 5'h00;
    endtask

    // bounded poll of the interface supply, the host's view of power state
    task automatic wait_sup(input logic v);
        for (int i = 0; i < 80; i++)
            if (interface_supply_on !== v) @(negedge clk_sys);
        chk(interface_supply_on === v, "interface supply level");
    endtask

    task automatic pulse_pc(input int n);
        pc_n = 1'b0;
        cyc(n);
        pc_n = 1'b1;
    endtask

    task automatic pon;
        pulse_pc(8);
        wait_sup(1'b1);
    endtask

    task automatic func(input logic [7:0] v);
        fvalue = v;
        fvalid = 1'b1;
        cyc(1);
        fvalid = 1'b0;
    endtask

    task automatic final_report;
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // =========================================================
    // scenarios
    task automatic t_idle;
        chk(interface_supply_on === 1'b0 && pins_tristate === 1'b1 && regulators_on === 1'b0, "reset outputs");
        cyc(4);
        clr();
        off_cmd = 1'b1;
        cyc(1);
        off_cmd = 1'b0;
        pulse_pc(2);
        cyc(10);
        chk(saw_ok === 1'b0 && interface_supply_on === 1'b0, "short pulse or command acted in off");
    endtask

    task automatic t_cmd_off;
        slow = 1'b1;
        pon();
        clr();
        off_cmd = 1'b1;
        cyc(1);
        off_cmd = 1'b0;
        chk(switch_off_ok === 1'b1 && save_req === 1'b1 && interface_supply_on === 1'b1, "no ok answer");
        cyc(1);
        chk(switch_off_ok === 1'b0, "ok answer longer than one cycle");
        wait_sup(1'b0);
        chk(saw_save === 1'b1, "graceful off skipped save");
        chk(saw_det === 1'b1 && pins_tristate === 1'b1 && regulators_on === 1'b0, "graceful off");
        cyc(30);
        chk(interface_supply_on === 1'b0, "left off state");
        slow = 1'b0;
    endtask

    // the host prefers the graceful paths; fast off is exercised once each way
    task automatic t_pin_fast;
        pon();
        clr();
        pulse_pc(8);
        wait_sup(1'b0);
        chk(saw_save === 1'b1 && saw_det === 1'b1, "pin off skipped save or detach");
        pon();
        clr();
        func(pors_pkg::FUNC_FAST_OFF);
        wait_sup(1'b0);
        chk(saw_save === 1'b1 && saw_det === 1'b0, "fast off by command");
        pon();
        clr();
        gpio = ~gpio;
        wait_sup(1'b0);
        chk(saw_save === 1'b1 && saw_det === 1'b0, "fast off by gpio");
    endtask

    task automatic t_reboot_gasp;
        pon();
        clr();
        func(pors_pkg::FUNC_REBOOT_DEF);
        wait_sup(1'b0);
        wait_sup(1'b1);
        chk(saw_save === 1'b1 && saw_det === 1'b1, "soft reboot");
        clr();
        lg_trig = 1'b1;
        cyc(3);
        chk(saw_gasp === 1'b0 && interface_supply_on === 1'b1, "last gasp while disabled");
        lg_en = 1'b1;
        cyc(1);
        lg_trig = 1'b0;
        wait_sup(1'b0);
        lg_en = 1'b0;
        chk(saw_gasp === 1'b1 && saw_save === 1'b1 && saw_det === 1'b1, "last gasp off");
    endtask

    // abrupt paths, used by the host only as a last resort
    task automatic t_abrupt;
        pon();
        clr();
        rs_n = 1'b0;
        cyc(10);
        wait_sup(1'b0);
        rs_n = 1'b1;
        cyc(20);
        chk(saw_save === 1'b0 && interface_supply_on === 1'b0, "reset pin shutdown");
        pon();
        clr();
        pc_n = 1'b0;
        cyc(30);
        pc_n = 1'b1;
        wait_sup(1'b1);
        chk(saw_low === 1'b1 && saw_save === 1'b0, "long hold reboot");
        clr();
        supply = 1'b0;
        wait_sup(1'b0);
        chk(saw_save === 1'b0, "supply loss saved");
        pulse_pc(8);
        cyc(10);
        chk(interface_supply_on === 1'b0, "switched on without supply");
        supply = 1'b1;
        cyc(5);
        pon();
    endtask

    initial
    begin
        clr();
        cyc(6);
        srst = 1'b0;
        cyc(1);
        t_idle();
        t_cmd_off();
        t_pin_fast();
        t_reboot_gasp();
        t_abrupt();
        final_report();
    end
endmodule
